// *** core/cms_pkg.sv ***
// Constants shared by the chopper mode select and standstill logic
package cms_pkg;
	// Register byte offsets
	localparam logic [7:0] ADDR_CONFIG   = 8'h00;
	localparam logic [7:0] ADDR_THRESH   = 8'h04;
	localparam logic [7:0] ADDR_INTERVAL = 8'h08;
	localparam logic [7:0] ADDR_STATUS   = 8'h0C;
	localparam logic [7:0] ADDR_PWM_OFS  = 8'h10;
	localparam logic [7:0] ADDR_INT_STAT = 8'h14;
	localparam logic [7:0] ADDR_INT_MASK = 8'h18;
	// Config register field positions
	localparam int CFG_DIS_BIT  = 0;
	localparam int CFG_OPT_LSB  = 1;
	localparam int CFG_HOLD_LSB = 8;
	localparam int CFG_PD_LSB   = 16;
	localparam int CFG_HRD_LSB  = 24;
	// Status register field positions
	localparam int ST_VMODE_BIT = 0;
	localparam int ST_OL_LSB    = 1;
	localparam int ST_SS_LSB    = 3;
	localparam int ST_SUM_LSB   = 8;
	localparam int ST_SCALE_LSB = 16;
	// Interrupt bit positions
	localparam int IRQ_MODE  = 0;
	localparam int IRQ_OLA   = 1;
	localparam int IRQ_OLB   = 2;
	localparam int IRQ_LIMIT = 3;
	localparam int IRQ_W     = 4;
	// Reset values
	localparam logic [31:0] CONFIG_RST = 32'h0000_0000;
	localparam logic [19:0] THRESH_RST = 20'h0_0000;
	localparam logic [7:0]  PWM_OFS_RST = 8'h24;
	localparam logic [3:0]  INT_MASK_RST = 4'h0;
	// Limits and timing
	localparam logic [7:0]  AMP_LIMIT     = 8'hFF;
	localparam logic [3:0]  OL_FULLSTEPS  = 4'h4;
	localparam logic [15:0] TICK_CYCLES   = 16'h0400;
	localparam logic [8:0]  SCALE_MAX     = 9'h0FF;
	localparam logic [8:0]  SCALE_MIN     = 9'h101;
	// Standstill option encoding
	typedef enum logic [1:0] {
		SS_NORMAL    = 2'b00,
		SS_STANDSTILL_OPTION_SELECT = 2'b01,
		SS_SHORT_LS  = 2'b10,
		SS_SHORT_HS  = 2'b11
	} standstill_t;
endpackage

// *** core/cms_ctrl_if.sv ***
// Signals between the mode core and its open-load and standstill helpers
`timescale 1ns/1ps
interface cms_ctrl_if;
	logic       voltageMode;
	logic       fullStep;
	logic [1:0] coilReached;
	logic [1:0] openLoad;
	logic       stepPulse;
	logic [7:0] powerdownDelay;
	logic [3:0] holdRampDelay;
	logic       delayDone;
	modport core  (output voltageMode, fullStep, coilReached, stepPulse,
		powerdownDelay, holdRampDelay, input openLoad, delayDone);
	modport olMon (input voltageMode, fullStep, coilReached, output openLoad);
	modport ssTmr (input stepPulse, powerdownDelay, holdRampDelay, output delayDone);
endinterface // cms_ctrl_if

// *** core/open_load_monitor.sv ***
// Per-coil open-load flags from full steps without reaching target current
`timescale 1ns/1ps
module open_load_monitor (
	// Clock and reset
	input  wire logic   sys_clk,
	input  wire logic   rst,
	// Helper link
	cms_ctrl_if.olMon   ctl
);
	logic [3:0] missCnt [2];
	wire  [1:0] flagNow;

	// Count full steps since each coil last reached its target
	for (genvar c = 0; c < 2; c++) begin : g_coil
		always_ff @(posedge sys_clk or posedge rst) begin
			if (rst) begin
				missCnt[c] <= 4'h0;
			end else if (!ctl.voltageMode || ctl.coilReached[c]) begin
				missCnt[c] <= 4'h0;
			end else if (ctl.fullStep && missCnt[c] != cms_pkg::OL_FULLSTEPS) begin
				missCnt[c] <= missCnt[c] + 4'h1;
			end
		end
		// Saturated count holds the flag steady for a broken winding
		assign flagNow[c] = (missCnt[c] == cms_pkg::OL_FULLSTEPS);

		ol_clear_a: assert property (@(posedge sys_clk) disable iff (rst)
			(ctl.voltageMode && ctl.coilReached[c]) |=> !ctl.openLoad[c])
			else $error("open-load flag kept after coil reached target");
	end
	// One driver for the whole flag vector on the helper link
	assign ctl.openLoad = flagNow;
endmodule // open_load_monitor

// *** core/standstill_timer.sv ***
// Standstill delay timer: power-down plus hold ramp delay in ticks
`timescale 1ns/1ps
module standstill_timer (
	// Clock and reset
	input  wire logic   sys_clk,
	input  wire logic   rst,
	// Helper link
	cms_ctrl_if.ssTmr   ctl
);
	logic [15:0] tickCnt;
	logic [8:0]  stillTicks;
	wire  [8:0]  delayTarget = {1'b0, ctl.powerdownDelay} + {5'h00, ctl.holdRampDelay};
	wire         tick        = (tickCnt == cms_pkg::TICK_CYCLES - 16'h0001);

	// Tick prescaler, restarted by every step
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			tickCnt <= 16'h0000;
		end else begin
			tickCnt <= (tick || ctl.stepPulse) ? 16'h0000 : tickCnt + 16'h0001;
		end
	end

	// Standstill time in ticks, saturating at the delay target
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			stillTicks <= 9'h000;
		end else if (ctl.stepPulse) begin
			stillTicks <= 9'h000;
		end else if (tick && stillTicks < delayTarget) begin
			stillTicks <= stillTicks + 9'h001;
		end
	end
	assign ctl.delayDone = !ctl.stepPulse && (stillTicks >= delayTarget);

	step_restart_a: assert property (@(posedge sys_clk) disable iff (rst)
		ctl.stepPulse |=> (stillTicks == 9'h000))
		else $error("standstill time not restarted by a step");
endmodule // standstill_timer

// *** core/chopper_mode_select_standstill.sv ***
// Chopper mode select, regulation hold, open-load, amplitude and standstill control
// Function
// - Voltage chopper at low velocity, current chopper above the threshold.
// - Threshold can be loaded from one-time-programmable memory.
// - Zero threshold means voltage-mode chopping only.
// - Regulation value held while in current chopper, resumed afterwards.
// - One open-load flag per coil in voltage mode.
// - Open-load set when target current not reached in recent full steps.
// - Interrupted coil keeps its open-load flag steadily set.
// - Summed amplitude readable; 255 means current cannot be sustained.
// - Standstill options only while voltage mode is used.
// - Standstill option applied when standstill current is zero.
// - Option engages after power-down plus hold ramp delay.
// - Regulation frozen once target current is zero.
// - Option codes: normal, standstill_option_select, low-side short, high-side short.
// - Voltage-mode disable is pin XOR configuration flag.
// - Threshold range 0 to 1048575 in step-interval units.
//
// Design decisions made here: the register offsets and register access over APB.
`timescale 1ns/1ps
module chopper_mode_select_standstill (
	// Clock and reset
	input  wire logic               sys_clk,
	input  wire logic               rst,
	// APB slave
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [7:0]         paddr,
	input  wire logic [31:0]        pwdata,
	output logic [31:0]             prdata,
	output logic                    pready,
	output logic                    pslverr,
	// Step timing
	input  wire logic               stepPulse,
	input  wire logic               fullStep,
	input  wire logic [19:0]        stepInterval,
	// Pins and one-time-programmable memory
	input  wire logic               chopperSelectPin,
	input  wire logic               otpLoad,
	input  wire logic [19:0]        otpThreshold,
	// Current regulator
	input  wire logic               regUpdate,
	input  wire logic signed [4:0]  regDelta,
	input  wire logic [1:0]         coilReached,
	// Outputs
	output logic                    voltageMode,
	output cms_pkg::standstill_t    standstillMode,
	output logic [7:0]              pwmAmplitudeSum,
	output logic [1:0]              openLoad,
	output logic                    irq
);
	// Registers
	logic [31:0]             config_q;
	logic [19:0]             velocitySwitchThreshold;
	logic [7:0]              pwmOfs;
	logic [3:0]              intStatus;
	logic [3:0]              intMask;
	logic signed [8:0]       scaleAuto;
	logic [1:0]              openLoadPrev;

	cms_ctrl_if ctl ();

	// Clamp a signed sum into the 0..255 amplitude range
	function automatic logic [7:0] clampAmp(input logic signed [10:0] v);
		if (v < 11'sd0) begin
			return 8'h00;
		end else if (v > 11'sd255) begin
			return cms_pkg::AMP_LIMIT;
		end else begin
			return v[7:0];
		end
	endfunction

	// Clamp the regulator state to its signed range
	function automatic logic signed [8:0] clampScale(input logic signed [10:0] v);
		if (v > 11'sd255) begin
			return cms_pkg::SCALE_MAX;
		end else if (v < -11'sd255) begin
			return cms_pkg::SCALE_MIN;
		end else begin
			return v[8:0];
		end
	endfunction

	// Configuration fields
	wire        cfgDisable        = config_q[cms_pkg::CFG_DIS_BIT];
	wire [1:0]  standstillOptionSelect = config_q[cms_pkg::CFG_OPT_LSB +: 2];
	wire [4:0]  standstillCurrent = config_q[cms_pkg::CFG_HOLD_LSB +: 5];
	wire        holdZero          = (standstillCurrent == 5'h00);

	// Mode decision
	wire disableEff = chopperSelectPin ^ cfgDisable;
	wire thrZero    = (velocitySwitchThreshold == cms_pkg::THRESH_RST);
	wire slowEnough = thrZero || (stepInterval >= velocitySwitchThreshold);
	wire next_voltageMode = !disableEff && slowEnough;

	// Standstill engagement: zero hold current, delay done, voltage mode only
	wire engaged = holdZero && ctl.delayDone && voltageMode;

	// Regulator and amplitude arithmetic
	wire signed [10:0] scaleSum = 11'(scaleAuto) + 11'(regDelta);
	wire signed [10:0] ampSum   = 11'(signed'({1'b0, pwmOfs})) + 11'(scaleAuto);
	wire [7:0] next_ampSum      = clampAmp(ampSum);

	// APB decode
	wire setupPhase = psel && !penable;
	wire accessWr   = psel && penable && pwrite;
	wire accessRd   = psel && penable && !pwrite;
	wire hitConfig  = (paddr == cms_pkg::ADDR_CONFIG);
	wire hitThresh  = (paddr == cms_pkg::ADDR_THRESH);
	wire hitIntStat = (paddr == cms_pkg::ADDR_INT_STAT);
	wire hitMask    = (paddr == cms_pkg::ADDR_INT_MASK);
	wire hitPwmOfs  = (paddr == cms_pkg::ADDR_PWM_OFS);
	wire addrHit    = hitConfig || hitThresh || hitIntStat || hitMask || hitPwmOfs
		|| (paddr == cms_pkg::ADDR_INTERVAL) || (paddr == cms_pkg::ADDR_STATUS);
	wire wrThresh   = accessWr && hitThresh;

	assign pready  = psel && penable;
	assign pslverr = pready && !addrHit;

	// Status word
	wire [31:0] statusWord = (32'(voltageMode) << cms_pkg::ST_VMODE_BIT)
		| (32'(openLoad) << cms_pkg::ST_OL_LSB)
		| (32'(standstillMode) << cms_pkg::ST_SS_LSB)
		| (32'(pwmAmplitudeSum) << cms_pkg::ST_SUM_LSB)
		| (32'(unsigned'(scaleAuto)) << cms_pkg::ST_SCALE_LSB);

	// Read selection
	wire [31:0] readMux =
		hitConfig  ? config_q :
		hitThresh  ? 32'(velocitySwitchThreshold) :
		(paddr == cms_pkg::ADDR_INTERVAL) ? 32'(stepInterval) :
		(paddr == cms_pkg::ADDR_STATUS)   ? statusWord :
		hitPwmOfs  ? 32'(pwmOfs) :
		hitIntStat ? 32'(intStatus) :
		hitMask    ? 32'(intMask) : 32'h0000_0000;

	// Interrupt events and read clear of the bits that were returned
	wire [3:0] events = {
		(next_ampSum == cms_pkg::AMP_LIMIT) && (pwmAmplitudeSum != cms_pkg::AMP_LIMIT),
		ctl.openLoad[1] && !openLoadPrev[1],
		ctl.openLoad[0] && !openLoadPrev[0],
		next_voltageMode != voltageMode
	};
	wire [3:0] clrMask   = (accessRd && hitIntStat) ? prdata[3:0] : 4'h0;
	wire [3:0] next_intStatus = (intStatus & ~clrMask) | events;

	// Helper link drive
	assign ctl.voltageMode    = voltageMode;
	assign ctl.fullStep       = fullStep;
	assign ctl.coilReached    = coilReached;
	assign ctl.stepPulse      = stepPulse;
	assign ctl.powerdownDelay = config_q[cms_pkg::CFG_PD_LSB +: 8];
	assign ctl.holdRampDelay  = config_q[cms_pkg::CFG_HRD_LSB +: 4];
	assign irq = |(intStatus & intMask);

	// Read data captured in the setup phase
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			prdata <= 32'h0000_0000;
		end else if (setupPhase) begin
			prdata <= pwrite ? 32'h0000_0000 : readMux;
		end
	end

	// Writable configuration registers
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			config_q <= cms_pkg::CONFIG_RST;
			pwmOfs   <= cms_pkg::PWM_OFS_RST;
			intMask  <= cms_pkg::INT_MASK_RST;
		end else if (accessWr) begin
			if (hitConfig) begin
				config_q <= pwdata;
			end
			if (hitPwmOfs) begin
				pwmOfs <= pwdata[7:0];
			end
			if (hitMask) begin
				intMask <= pwdata[3:0];
			end
		end
	end

	// Threshold: bus write wins over a memory load in the same cycle
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			velocitySwitchThreshold <= cms_pkg::THRESH_RST;
		end else if (wrThresh) begin
			velocitySwitchThreshold <= pwdata[19:0];
		end else if (otpLoad) begin
			velocitySwitchThreshold <= otpThreshold;
		end
	end

	// Mode, interrupt status and flag history
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			voltageMode  <= 1'b0;
			intStatus    <= 4'h0;
			openLoadPrev <= 2'b00;
		end else begin
			voltageMode  <= next_voltageMode;
			intStatus    <= next_intStatus;
			openLoadPrev <= ctl.openLoad;
		end
	end

	// Regulator state: only moves in voltage mode with nonzero target current
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			scaleAuto <= 9'sd0;
		end else if (regUpdate && voltageMode && !engaged) begin
			scaleAuto <= clampScale(scaleSum);
		end
	end

	// Registered outputs: amplitude, open-load flags, standstill option
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			pwmAmplitudeSum <= 8'h00;
			openLoad        <= 2'b00;
			standstillMode  <= cms_pkg::SS_NORMAL;
		end else begin
			pwmAmplitudeSum <= next_ampSum;
			openLoad        <= ctl.openLoad;
			standstillMode  <= engaged ? cms_pkg::standstill_t'(standstillOptionSelect)
				: cms_pkg::SS_NORMAL;
		end
	end

	// Helpers
	open_load_monitor u_olMon (
		.sys_clk (sys_clk),
		.rst     (rst),
		.ctl     (ctl.olMon)
	);

	standstill_timer u_ssTmr (
		.sys_clk (sys_clk),
		.rst     (rst),
		.ctl     (ctl.ssTmr)
	);

	// Checks on mode selection
	thr_zero_a: assert property (@(posedge sys_clk) disable iff (rst)
		(thrZero && !disableEff) |=> voltageMode)
		else $error("zero threshold left voltage mode");

	fast_mode_a: assert property (@(posedge sys_clk) disable iff (rst)
		(!thrZero && stepInterval < velocitySwitchThreshold) |=> !voltageMode)
		else $error("voltage mode kept above threshold velocity");

	xor_disable_a: assert property (@(posedge sys_clk) disable iff (rst)
		(chopperSelectPin != cfgDisable) |=> !voltageMode)
		else $error("voltage mode despite effective disable");

	// Checks on regulator hold and freeze, amplitude limit and threshold load from memory
	scale_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
		!voltageMode |=> (scaleAuto == $past(scaleAuto)))
		else $error("regulator state moved in current chopper");

	freeze_zero_a: assert property (@(posedge sys_clk) disable iff (rst)
		engaged |=> (scaleAuto == $past(scaleAuto)))
		else $error("regulator state moved at zero target current");

	amp_limit_a: assert property (@(posedge sys_clk) disable iff (rst)
		(ampSum >= 11'sd255) |=> (pwmAmplitudeSum == cms_pkg::AMP_LIMIT))
		else $error("amplitude sum not at limit");

	otp_load_a: assert property (@(posedge sys_clk) disable iff (rst)
		(otpLoad && !wrThresh) |=> (velocitySwitchThreshold == $past(otpThreshold)))
		else $error("threshold not loaded from memory");

	// Standstill option follows engagement, and clears on a step
	sequence engageSeq;
		engaged ##1 (standstillMode == cms_pkg::standstill_t'($past(standstillOptionSelect)));
	endsequence
	option_a: assert property (@(posedge sys_clk) disable iff (rst)
		engaged |-> engageSeq)
		else $error("standstill option not applied");

	step_release_a: assert property (@(posedge sys_clk) disable iff (rst)
		(stepPulse || !voltageMode) |=> (standstillMode == cms_pkg::SS_NORMAL))
		else $error("standstill option held while moving or in current chopper");

	// Checks on open-load flags
	sequence flagsDropSeq;
		##2 (openLoad == 2'b00);
	endsequence

	ol_off_a: assert property (@(posedge sys_clk) disable iff (rst)
		!voltageMode |-> flagsDropSeq)
		else $error("open-load flag outside voltage mode");

	ola_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
		(ctl.openLoad[0] && voltageMode && !coilReached[0]) |=> ctl.openLoad[0])
		else $error("coil A open-load flag dropped");

	olb_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
		(ctl.openLoad[1] && voltageMode && !coilReached[1]) |=> ctl.openLoad[1])
		else $error("coil B open-load flag dropped");

	ola_rise_a: assert property (@(posedge sys_clk) disable iff (rst)
		$rose(ctl.openLoad[0]) |-> ($past(fullStep) && $past(voltageMode)))
		else $error("coil A open-load flag set without a full step");

	olb_rise_a: assert property (@(posedge sys_clk) disable iff (rst)
		$rose(ctl.openLoad[1]) |-> ($past(fullStep) && $past(voltageMode)))
		else $error("coil B open-load flag set without a full step");

	// Checks on amplitude, threshold and interrupts
	amp_floor_a: assert property (@(posedge sys_clk) disable iff (rst)
		(ampSum < 11'sd0) |=> (pwmAmplitudeSum == 8'h00))
		else $error("amplitude sum not clamped at zero");

	amp_track_a: assert property (@(posedge sys_clk) disable iff (rst)
		(ampSum >= 11'sd0 && ampSum < 11'sd255) |=> (pwmAmplitudeSum == 8'($past(ampSum))))
		else $error("amplitude sum not offset plus regulator");

	thr_write_a: assert property (@(posedge sys_clk) disable iff (rst)
		wrThresh |=> (velocitySwitchThreshold == 20'($past(pwdata))))
		else $error("threshold write not taken");

	event_set_a: assert property (@(posedge sys_clk) disable iff (rst)
		(events != 4'h0) |=> ((intStatus & $past(events)) == $past(events)))
		else $error("interrupt event lost to a read clear");

	mode_irq_a: assert property (@(posedge sys_clk) disable iff (rst)
		(voltageMode != $past(voltageMode)) |-> intStatus[cms_pkg::IRQ_MODE])
		else $error("mode change not flagged");

	// Checks on standstill option codes
	code_free_a: assert property (@(posedge sys_clk) disable iff (rst)
		(engaged && standstillOptionSelect == 2'd1) |=> standstillMode == cms_pkg::SS_STANDSTILL_OPTION_SELECT)
		else $error("code 1 is not freewheeling");

	code_low_a: assert property (@(posedge sys_clk) disable iff (rst)
		(engaged && standstillOptionSelect == 2'd2) |=> standstillMode == cms_pkg::SS_SHORT_LS)
		else $error("code 2 is not low-side short");

	code_high_a: assert property (@(posedge sys_clk) disable iff (rst)
		(engaged && standstillOptionSelect == 2'd3) |=> standstillMode == cms_pkg::SS_SHORT_HS)
		else $error("code 3 is not high-side short");

endmodule // chopper_mode_select_standstill

// *** tb/step_source.sv ***
// Step generator standing in front of the mode select logic
`timescale 1ns/1ps
module step_source #(
	parameter int CHOP_CYCLES = 512
) (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst,
	// Motion request
	input  wire logic        run,
	input  wire logic [19:0] period,
	// Step timing
	output logic             stepPulse,
	output logic             fullStep,
	output logic [19:0]      stepInterval
);
	logic [31:0] settle;
	logic [19:0] gap;
	logic [1:0]  micro;
	logic        ready;
	logic        fire;
	// Motor stays still after enable, then one step every period cycles
	assign ready = (settle >= 32'(128 * CHOP_CYCLES));
	assign fire  = run && ready && (gap >= period - 20'h0_0001);
	// Steps, full steps and the measured interval
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			settle       <= 32'h0000_0000;
			gap          <= 20'h0_0000;
			micro        <= 2'b00;
			stepPulse    <= 1'b0;
			fullStep     <= 1'b0;
			stepInterval <= 20'hF_FFFF;
		end else begin
			if (!ready) begin
				settle <= settle + 32'h0000_0001;
			end
			stepPulse <= fire;
			fullStep  <= fire && (micro == 2'b11);
			if (fire) begin
				micro        <= micro + 2'b01;
				stepInterval <= period;
			end
			// A stopped motor restarts from zero velocity
			gap <= (fire || !run) ? 20'h0_0000 : gap + 20'h0_0001;
		end
	end
endmodule // step_source

// *** tb/chopper_mode_select_standstill_tb.sv ***
// Self-checking bench for the chopper mode select and standstill block
`timescale 1ns/1ps
module chopper_mode_select_standstill_tb;
	// Clock, reset and bus
	logic                 sys_clk = 1'b0;
	logic                 rst = 1'b1;
	logic                 psel = 1'b0;
	logic                 penable = 1'b0;
	logic                 pwrite = 1'b0;
	logic [7:0]           paddr = 8'h00;
	logic [31:0]          pwdata = 32'h0000_0000;
	logic [31:0]          prdata;
	logic                 pready;
	logic                 pslverr;
	// Step source, pins and regulator
	logic                 run = 1'b0;
	logic [19:0]          period = 20'h0_0008;
	logic                 stepPulse;
	logic                 fullStep;
	logic [19:0]          stepInterval;
	logic                 chopperSelectPin = 1'b0;
	logic                 otpLoad = 1'b0;
	logic [19:0]          otpThreshold = 20'h0_0000;
	logic                 regUpdate = 1'b0;
	logic signed [4:0]    regDelta = 5'h00;
	logic [1:0]           coilReached = 2'b00;
	// Observed outputs and bookkeeping
	logic                 voltageMode;
	cms_pkg::standstill_t standstillMode;
	logic [7:0]           pwmAmplitudeSum;
	logic [1:0]           openLoad;
	logic                 irq;
	logic [31:0]          rd;
	logic                 er;
	int                   errors = 0;
	int                   n_compared = 0;

	// Free running clock
	always #10 sys_clk = ~sys_clk;

	step_source #(.CHOP_CYCLES(4)) steps (.sys_clk(sys_clk), .rst(rst), .run(run),
		.period(period), .stepPulse(stepPulse), .fullStep(fullStep),
		.stepInterval(stepInterval));

	chopper_mode_select_standstill DUT (.sys_clk(sys_clk), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .stepPulse(stepPulse),
		.fullStep(fullStep), .stepInterval(stepInterval),
		.chopperSelectPin(chopperSelectPin), .otpLoad(otpLoad),
		.otpThreshold(otpThreshold), .regUpdate(regUpdate), .regDelta(regDelta),
		.coilReached(coilReached), .voltageMode(voltageMode),
		.standstillMode(standstillMode), .pwmAmplitudeSum(pwmAmplitudeSum),
		.openLoad(openLoad), .irq(irq));

	// Verdict and end of run
	task automatic give_verdict;
		if (errors == 0 && n_compared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Compare and count
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One APB transfer; waits for pready under a bound
	task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
		int n;
		@(posedge sys_clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= addr;
		pwdata  <= wd;
		@(posedge sys_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			errors++;
		end
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] addr, input logic [31:0] wd);
		apb(1'b1, addr, wd);
	endtask

	task automatic rdc(input logic [7:0] addr, input logic [31:0] exp);
		apb(1'b0, addr, 32'h0000_0000);
		chk(rd, exp);
	endtask

	// Let n edges pass, then sample settled outputs
	task automatic after(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	// One regulator increment
	task automatic bump(input logic [4:0] d);
		@(posedge sys_clk);
		regUpdate <= 1'b1;
		regDelta  <= d;
		@(posedge sys_clk);
		regUpdate <= 1'b0;
	endtask

	function automatic logic [31:0] cfg(input logic dis, input logic [1:0] opt,
			input logic [4:0] hold, input logic [7:0] pd, input logic [3:0] hrd);
		return (32'(dis) << cms_pkg::CFG_DIS_BIT) | (32'(opt) << cms_pkg::CFG_OPT_LSB)
			| (32'(hold) << cms_pkg::CFG_HOLD_LSB) | (32'(pd) << cms_pkg::CFG_PD_LSB)
			| (32'(hrd) << cms_pkg::CFG_HRD_LSB);
	endfunction

	// Main sequence
	initial begin
		repeat (10) @(posedge sys_clk);
		rst <= 1'b0;
		rdc(cms_pkg::ADDR_CONFIG, cms_pkg::CONFIG_RST);
		rdc(cms_pkg::ADDR_PWM_OFS, 32'(cms_pkg::PWM_OFS_RST));
		rdc(cms_pkg::ADDR_INT_MASK, 32'(cms_pkg::INT_MASK_RST));
		chk(32'(er), 32'h0000_0000);
		rdc(8'h1C, 32'h0000_0000);
		chk(32'(er), 32'h0000_0001);
		wr(cms_pkg::ADDR_THRESH, 32'hFFFF_FFFF);
		rdc(cms_pkg::ADDR_THRESH, 32'h000F_FFFF);
		wr(cms_pkg::ADDR_CONFIG, cfg(0, 0, 1, 0, 0));
		wr(cms_pkg::ADDR_THRESH, 32'h0000_0000);
		// Zero threshold keeps voltage mode at a short interval
		@(posedge sys_clk) period <= 20'h0_0002;
		@(posedge sys_clk) run <= 1'b1;
		after(700);
		chk(32'(voltageMode), 32'h0000_0001);
		// Threshold taken from the interval read at the changeover speed
		@(posedge sys_clk) period <= 20'h0_0064;
		after(300);
		rdc(cms_pkg::ADDR_INTERVAL, 32'h0000_0064);
		wr(cms_pkg::ADDR_THRESH, rd);
		after(5);
		chk(32'(voltageMode), 32'h0000_0001);
		@(posedge sys_clk) period <= 20'h0_0063;
		after(300);
		chk(32'(voltageMode), 32'h0000_0000);
		@(posedge sys_clk) period <= 20'h0_0064;
		after(300);
		// Pin and disable flag combine by exclusive or
		for (int i = 0; i < 4; i++) begin
			@(posedge sys_clk) chopperSelectPin <= i[0];
			wr(cms_pkg::ADDR_CONFIG, cfg(i[1], 0, 1, 0, 0));
			after(3);
			chk(32'(voltageMode), 32'(i[0] == i[1]));
		end
		@(posedge sys_clk) chopperSelectPin <= 1'b0;
		wr(cms_pkg::ADDR_CONFIG, cfg(0, 0, 1, 0, 0));
		// Regulation held across the current chopper phase
		repeat (3) bump(5'h05);
		apb(1'b0, cms_pkg::ADDR_STATUS, 32'h0000_0000);
		chk(32'(rd[24:16]), 32'h0000_000F);
		@(posedge sys_clk) period <= 20'h0_0063;
		after(300);
		bump(5'h05);
		apb(1'b0, cms_pkg::ADDR_STATUS, 32'h0000_0000);
		chk(32'(rd[24:16]), 32'h0000_000F);
		@(posedge sys_clk) period <= 20'h0_0064;
		after(300);
		bump(5'h05);
		after(3);
		chk(32'(pwmAmplitudeSum), 32'h0000_0038);
		// Threshold loaded from one-time memory
		@(posedge sys_clk) otpLoad <= 1'b1;
		otpThreshold <= 20'hA_BCDE;
		@(posedge sys_clk) otpLoad <= 1'b0;
		rdc(cms_pkg::ADDR_THRESH, 32'h000A_BCDE);
		after(3);
		chk(32'(voltageMode), 32'h0000_0000);
		wr(cms_pkg::ADDR_THRESH, 32'h0000_0000);
		// Amplitude limit event, masked then unmasked
		apb(1'b0, cms_pkg::ADDR_INT_STAT, 32'h0000_0000);
		wr(cms_pkg::ADDR_PWM_OFS, 32'h0000_00FF);
		after(3);
		chk(32'(pwmAmplitudeSum), 32'h0000_00FF);
		chk(32'(irq), 32'h0000_0000);
		wr(cms_pkg::ADDR_INT_MASK, 32'h0000_0008);
		after(1);
		chk(32'(irq), 32'h0000_0001);
		apb(1'b0, cms_pkg::ADDR_INT_STAT, 32'h0000_0000);
		chk(32'(rd[3]), 32'h0000_0001);
		after(2);
		chk(32'(irq), 32'h0000_0000);
		wr(cms_pkg::ADDR_PWM_OFS, 32'h0000_0024);
		// Open load per coil, steady on a coil that never reaches target
		@(posedge sys_clk) period <= 20'h0_0008;
		@(posedge sys_clk) coilReached <= 2'b11;
		after(3);
		@(posedge sys_clk) coilReached <= 2'b00;
		after(3);
		chk(32'(openLoad), 32'h0000_0000);
		after(200);
		chk(32'(openLoad), 32'h0000_0003);
		@(posedge sys_clk) coilReached <= 2'b01;
		repeat (4) begin
			after(40);
			chk(32'(openLoad), 32'h0000_0002);
		end
		apb(1'b0, cms_pkg::ADDR_INT_STAT, 32'h0000_0000);
		chk(32'(rd[2:1]), 32'h0000_0003);
		@(posedge sys_clk) chopperSelectPin <= 1'b1;
		after(4);
		chk(32'(openLoad), 32'h0000_0000);
		@(posedge sys_clk) chopperSelectPin <= 1'b0;
		// Standstill options with zero hold current and no delay
		@(posedge sys_clk) run <= 1'b0;
		coilReached <= 2'b00;
		for (int k = 0; k < 4; k++) begin
			wr(cms_pkg::ADDR_CONFIG, cfg(0, k[1:0], 0, 0, 0));
			after(5);
			chk(32'(standstillMode), 32'(k));
		end
		bump(5'h05);
		apb(1'b0, cms_pkg::ADDR_STATUS, 32'h0000_0000);
		chk(32'(rd[24:16]), 32'h0000_0014);
		wr(cms_pkg::ADDR_CONFIG, cfg(1, 1, 0, 0, 0));
		after(5);
		chk(32'(standstillMode), 32'h0000_0000);
		wr(cms_pkg::ADDR_CONFIG, cfg(0, 1, 1, 0, 0));
		after(5);
		chk(32'(standstillMode), 32'h0000_0000);
		// Option waits for power-down plus ramp delay after the last step
		wr(cms_pkg::ADDR_CONFIG, cfg(0, 2, 0, 1, 1));
		@(posedge sys_clk) run <= 1'b1;
		after(10);
		@(posedge sys_clk) run <= 1'b0;
		after(1500);
		chk(32'(standstillMode), 32'h0000_0000);
		after(700);
		chk(32'(standstillMode), 32'h0000_0002);
		give_verdict();
	end

	// Watchdog against a hang
	initial begin
		#(20 * 20000);
		errors++;
		give_verdict();
	end
endmodule // chopper_mode_select_standstill_tb
